// ---- oag_map.svh ----
// oag_map.svh: named offsets, field positions, reset values and address pieces
// assumes inclusion by the operand address generator module only
`ifndef OAG_MAP_SVH
`define OAG_MAP_SVH
// register byte offsets on the apb slave
`define OAG_REG_CTRL     8'h00
`define OAG_REG_SP       8'h04
`define OAG_REG_STAT     8'h08
`define OAG_REG_LAST     8'h0c
// field positions
`define OAG_CTRL_LOC     0
`define OAG_CTRL_BANK_LO 1
`define OAG_CTRL_BANK_HI 3
`define OAG_STAT_BUSY    0
`define OAG_STAT_ERR     1
// reset values
`define OAG_CTRL_RST     4'h0
`define OAG_SP_RST       24'h000000
`define OAG_PTR_RST      24'h000000
`define OAG_WORD_ZERO    32'h00000000
// address pieces
`define OAG_LOC_LOW      4'h0
`define OAG_LOC_HIGH     4'hf
`define OAG_TOP_ZERO     4'h0
`define OAG_FILL_ONES    6'h3f
`define OAG_MID_ONE      2'b10
`define OAG_MID_TWO      2'b01
`define OAG_MID_TWO_SFR  2'b11
`define OAG_SFR_PAGE     8'hff
`define OAG_SFR_SPLIT    8'h20
`define OAG_P16_MAX_ONE  8'hfe
`define OAG_P16_MAX_TWO  8'h1e
`define OAG_G24_MAX_ONE  8'hfd
`define OAG_IND_TOP      8'h00
`define OAG_SHORT_TOP    8'hff
`define OAG_HI_WRAP      16'hfe00
`define OAG_ONE24        24'h000001
`define OAG_ONE16        16'h0001
// data sizes, pointer selectors and fetch counts
`define OAG_SIZE_NONE    2'h0
`define OAG_SIZE_TWO     2'h2
`define OAG_SIZE_THREE   2'h3
`define OAG_SEL_FOUR     2'h0
`define OAG_SEL_USER     2'h1
`define OAG_SEL_SIX      2'h2
`define OAG_SEL_SEVEN    2'h3
`define OAG_CNT_ZERO     2'h0
`define OAG_CNT_ONE      2'h1
`define OAG_LAST16       2'h1
`define OAG_LAST24       2'h2
`endif

// ---- oag_mem_model.sv ----
// oag_mem_model.sv: byte memory on the far side of the operand fetch port
// assumes one clock; the byte at address a is a[7:0]^a[15:8]^5a
`timescale 1ns/1ps
module oag_mem_model (
	input  wire logic        clk_sys,
	input  wire logic [1:0]  stall,
	input  wire logic        memRdReq,
	input  wire logic [23:0] memRdAddr,
	output logic             memRdAck,
	output logic [7:0]       memRdData
);
	logic [1:0] waitCnt;
	// start idle so the first edges see known levels
	initial begin
		memRdAck = 1'h0;
		waitCnt = 2'h0;
		memRdData = 8'h00;
	end
	// ack a held request after stall cycles; data toggles when no request is held and after an ack, and holds while waiting
	always @(posedge clk_sys) begin
		if (memRdAck || !memRdReq) begin
			memRdAck  <= 1'h0;
			waitCnt   <= 2'h0;
			memRdData <= ~memRdData;
		end else if (waitCnt == stall) begin
			memRdAck  <= 1'h1;
			memRdData <= memRdAddr[7:0] ^ memRdAddr[15:8] ^ 8'h5a;
		end else begin
			waitCnt <= waitCnt + 2'h1;
		end
	end
endmodule : oag_mem_model

// ---- oag_operand_address_generator.sv ----
// oag_operand_address_generator.sv: operand effective-address generation with apb control
// assumes one clock, decoder and memory read port on that clock, apb master on it too
// Function
// - direct24 uses immediate unchanged as address
// - low setting maps short offsets into fd20-ff1f
// - high setting adds f0000 to short addresses
// - middle bits 10, 01 or 11 by class
// - word high byte after fdff is fe00
// - word to ff1e, three bytes to fefd
// - sfr mode offsets 256-byte window at ff00
// - low 32 sfr bytes only via short
// - ind16 reads two bytes, top byte zero
// - ind24 reads three bytes fd20-fefd as address
// - system stack pointer or user pointer by op
// - push pair decrements stack pointer by two
// - register indirect uses banked 24-bit pointer
// - post step by size up or down
// - restricted class allows limited pointer forms
`timescale 1ns/1ps
`include "oag_map.svh"
module oag_operand_address_generator (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic [7:0]           paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 reqValid,
	input  wire oag_pkg::oag_mode_type reqMode,
	input  wire logic [23:0]          reqImm,
	input  wire logic                 reqClassTwo,
	input  wire logic [1:0]           reqSize,
	input  wire logic [1:0]           reqPtrSel,
	input  wire oag_pkg::oag_step_type reqStep,
	input  wire logic                 reqRestricted,
	output logic                      reqReady,
	input  wire logic                 ptrWrEn,
	input  wire logic [1:0]           ptrWrSel,
	input  wire logic [23:0]          ptrWrData,
	output logic                      memRdReq,
	output logic      [23:0]          memRdAddr,
	input  wire logic                 memRdAck,
	input  wire logic [7:0]           memRdData,
	output logic                      opValid,
	output logic      [23:0]          opAddr,
	output logic      [23:0]          opHiAddr,
	output logic                      opError
);
	import oag_pkg::*;

	logic [1:0]    rstSync_r;
	logic          rstn;
	logic [3:0]    ctrl_r, ctrl_nxt;
	logic [23:0]   sp_r, sp_nxt, last_r, last_nxt;
	logic          err_r, err_nxt;
	logic [31:0]   prdata_r, prdata_nxt;
	logic          pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	oag_state_type state_r, state_nxt;
	logic [1:0]    cnt_r, cnt_nxt, need_r, need_nxt;
	logic [15:0]   gather_r, gather_nxt;
	logic          memRdReq_r, memRdReq_nxt, reqReady_r, reqReady_nxt;
	logic [23:0]   memRdAddr_r, memRdAddr_nxt;
	logic          opValid_r, opValid_nxt, opError_r, opError_nxt;
	logic [23:0]   opAddr_r, opAddr_nxt, opHiAddr_r, opHiAddr_nxt;
	logic [23:0]   ptrFile_r [0:31];
	logic          ptrWe;
	logic [4:0]    ptrWIdx;
	logic [23:0]   ptrWData;
	logic          apbWrite, apbRead, ctrlWr, spWr, errClr;
	logic [3:0]    locNib;
	logic [2:0]    bank;
	logic [7:0]    imm8;
	logic          sfrSide, accept, rangeErr, indErr, restrictOk, reqErr;
	logic [1:0]    mid;
	logic [23:0]   shortAddr, sfrAddr, sizeExt, ptrVal, userVal;
	logic [23:0]   ptrStepUp, ptrStepDn, userStepUp, userStepDn, spStepUp, spStepDn;
	logic [4:0]    ptrIdx, userIdx;

	// reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_r <= 2'b00;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstn = rstSync_r[1];

	// address pieces from location setting and short offset
	assign locNib    = ctrl_r[`OAG_CTRL_LOC] ? `OAG_LOC_HIGH : `OAG_LOC_LOW;
	assign bank      = ctrl_r[`OAG_CTRL_BANK_HI:`OAG_CTRL_BANK_LO];
	assign imm8      = reqImm[7:0];
	assign sfrSide   = reqClassTwo && (imm8 < `OAG_SFR_SPLIT);
	assign mid       = !reqClassTwo ? `OAG_MID_ONE : (sfrSide ? `OAG_MID_TWO_SFR : `OAG_MID_TWO);
	assign shortAddr = {`OAG_TOP_ZERO, locNib, `OAG_FILL_ONES, mid, imm8};
	assign sfrAddr   = {`OAG_TOP_ZERO, locNib, `OAG_SFR_PAGE, imm8};

	// banked pointer reads and wrapping steps
	assign ptrIdx     = {bank, reqPtrSel};
	assign userIdx    = {bank, `OAG_SEL_USER};
	assign ptrVal     = ptrFile_r[ptrIdx];
	assign userVal    = ptrFile_r[userIdx];
	assign sizeExt    = 24'(reqSize);
	assign ptrStepUp  = ptrVal + sizeExt;
	assign ptrStepDn  = ptrVal - sizeExt;
	assign userStepUp = userVal + sizeExt;
	assign userStepDn = userVal - sizeExt;
	assign spStepUp   = sp_r + sizeExt;
	assign spStepDn   = sp_r - sizeExt;

	// request checks
	always_comb begin
		rangeErr = 1'b0;
		if (reqSize == `OAG_SIZE_TWO) begin
			rangeErr = reqClassTwo ? (sfrSide && imm8 > `OAG_P16_MAX_TWO) : (imm8 > `OAG_P16_MAX_ONE);
		end else if (reqSize == `OAG_SIZE_THREE) begin
			rangeErr = reqClassTwo ? sfrSide : (imm8 > `OAG_G24_MAX_ONE);
		end
		indErr = sfrSide || (!reqClassTwo && imm8 > `OAG_G24_MAX_ONE);
		if (reqMode == OAG_IND16) begin
			indErr = sfrSide || (!reqClassTwo && imm8 > `OAG_P16_MAX_ONE);
		end
		restrictOk = (reqPtrSel == `OAG_SEL_SIX) || (reqPtrSel == `OAG_SEL_SEVEN && reqStep == OAG_STEP_NONE);
		reqErr = (reqSize == `OAG_SIZE_NONE) || (reqRestricted && !restrictOk);
		case (reqMode)
			OAG_SHORT: reqErr = reqErr || rangeErr;
			OAG_SFR: reqErr = reqErr || (imm8 < `OAG_SFR_SPLIT);
			OAG_IND16, OAG_IND24: reqErr = reqErr || indErr;
			OAG_REGIND: reqErr = reqErr || (reqStep != OAG_STEP_NONE && reqPtrSel == `OAG_SEL_USER);
			default: reqErr = reqErr;
		endcase
	end
	assign accept = reqValid && reqReady_r && (state_r == OAG_IDLE);

	// address generation, stack and pointer updates, indirect fetch
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		need_nxt      = need_r;
		gather_nxt    = gather_r;
		memRdReq_nxt  = memRdReq_r;
		memRdAddr_nxt = memRdAddr_r;
		reqReady_nxt  = reqReady_r;
		opValid_nxt   = 1'b0;
		opError_nxt   = 1'b0;
		opAddr_nxt    = opAddr_r;
		sp_nxt        = spWr ? pwdata[23:0] : sp_r;
		ptrWe         = ptrWrEn;
		ptrWIdx       = {bank, ptrWrSel};
		ptrWData      = ptrWrData;
		case (state_r)
			OAG_IDLE: begin
				reqReady_nxt = 1'b1;
				if (accept) begin
					opValid_nxt = 1'b1;
					opError_nxt = reqErr;
					case (reqMode)
						OAG_DIRECT24: opAddr_nxt = reqImm;
						OAG_SHORT: opAddr_nxt = shortAddr;
						OAG_SFR: opAddr_nxt = sfrAddr;
						OAG_IND16, OAG_IND24: begin
							opAddr_nxt = shortAddr;
							if (!reqErr) begin
								opValid_nxt   = 1'b0;
								state_nxt     = OAG_FETCH;
								reqReady_nxt  = 1'b0;
								memRdReq_nxt  = 1'b1;
								memRdAddr_nxt = shortAddr;
								cnt_nxt       = `OAG_CNT_ZERO;
								need_nxt      = (reqMode == OAG_IND16) ? `OAG_LAST16 : `OAG_LAST24;
							end
						end
						OAG_PUSH: begin
							opAddr_nxt = spStepDn;
							if (!reqErr) begin
								sp_nxt = spStepDn;
							end
						end
						OAG_POP: begin
							opAddr_nxt = sp_r;
							if (!reqErr) begin
								sp_nxt = spStepUp;
							end
						end
						OAG_UPUSH: begin
							opAddr_nxt = userStepDn;
							if (!reqErr) begin
								ptrWe    = 1'b1;
								ptrWIdx  = userIdx;
								ptrWData = userStepDn;
							end
						end
						OAG_UPOP: begin
							opAddr_nxt = userVal;
							if (!reqErr) begin
								ptrWe    = 1'b1;
								ptrWIdx  = userIdx;
								ptrWData = userStepUp;
							end
						end
						OAG_REGIND: begin
							opAddr_nxt = ptrVal;
							if (!reqErr && reqStep != OAG_STEP_NONE) begin
								ptrWe    = 1'b1;
								ptrWIdx  = ptrIdx;
								ptrWData = (reqStep == OAG_STEP_INC) ? ptrStepUp : ptrStepDn;
							end
						end
						default: opError_nxt = 1'b1;
					endcase
				end
			end
			OAG_FETCH: begin
				if (memRdReq_r && memRdAck) begin
					if (cnt_r == need_r) begin
						memRdReq_nxt = 1'b0;
						state_nxt    = OAG_IDLE;
						reqReady_nxt = 1'b1;
						opValid_nxt  = 1'b1;
						if (need_r == `OAG_LAST16) begin
							opAddr_nxt = {`OAG_IND_TOP, memRdData, gather_r[7:0]};
						end else begin
							opAddr_nxt = {memRdData, gather_r};
						end
					end else begin
						if (cnt_r == `OAG_CNT_ZERO) begin
							gather_nxt[7:0] = memRdData;
						end else begin
							gather_nxt[15:8] = memRdData;
						end
						cnt_nxt       = cnt_r + `OAG_CNT_ONE;
						memRdAddr_nxt = {memRdAddr_r[23:16], memRdAddr_r[15:0] + `OAG_ONE16};
					end
				end
			end
			default: state_nxt = OAG_IDLE;
		endcase
		opHiAddr_nxt = opAddr_nxt + `OAG_ONE24;
		last_nxt     = opValid_nxt ? opAddr_nxt : last_r;
		err_nxt      = (err_r && !errClr) || (opValid_nxt && opError_nxt);
	end

	// apb slave: one wait state, writes land on the edge with pready high
	always_comb begin
		pready_nxt  = psel && penable && !pready_r;
		apbWrite    = psel && penable && pready_r && pwrite && !pslverr_r;
		apbRead     = psel && penable && !pready_r && !pwrite;
		prdata_nxt  = `OAG_WORD_ZERO;
		pslverr_nxt = 1'b0;
		ctrlWr      = apbWrite && paddr == `OAG_REG_CTRL;
		spWr        = apbWrite && paddr == `OAG_REG_SP;
		errClr      = apbWrite && paddr == `OAG_REG_STAT && pwdata[`OAG_STAT_ERR];
		ctrl_nxt    = ctrlWr ? pwdata[3:0] : ctrl_r;
		if (pready_nxt) begin
			case (paddr)
				`OAG_REG_CTRL: prdata_nxt[3:0] = ctrl_r;
				`OAG_REG_SP: prdata_nxt[23:0] = sp_r;
				`OAG_REG_STAT: begin
					prdata_nxt[`OAG_STAT_BUSY] = (state_r != OAG_IDLE);
					prdata_nxt[`OAG_STAT_ERR]  = err_r;
				end
				`OAG_REG_LAST: prdata_nxt[23:0] = last_r;
				default: pslverr_nxt = 1'b1;
			endcase
			if (!apbRead) begin
				prdata_nxt = `OAG_WORD_ZERO;
			end
		end
	end

	// state registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_r      <= `OAG_CTRL_RST;
			sp_r        <= `OAG_SP_RST;
			last_r      <= `OAG_SP_RST;
			err_r       <= 1'b0;
			prdata_r    <= `OAG_WORD_ZERO;
			pready_r    <= 1'b0;
			pslverr_r   <= 1'b0;
			state_r     <= OAG_IDLE;
			cnt_r       <= `OAG_CNT_ZERO;
			need_r      <= `OAG_CNT_ZERO;
			gather_r    <= 16'h0000;
			memRdReq_r  <= 1'b0;
			memRdAddr_r <= `OAG_SP_RST;
			reqReady_r  <= 1'b0;
			opValid_r   <= 1'b0;
			opError_r   <= 1'b0;
			opAddr_r    <= `OAG_SP_RST;
			opHiAddr_r  <= `OAG_SP_RST;
		end else begin
			ctrl_r      <= ctrl_nxt;
			sp_r        <= sp_nxt;
			last_r      <= last_nxt;
			err_r       <= err_nxt;
			prdata_r    <= prdata_nxt;
			pready_r    <= pready_nxt;
			pslverr_r   <= pslverr_nxt;
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			need_r      <= need_nxt;
			gather_r    <= gather_nxt;
			memRdReq_r  <= memRdReq_nxt;
			memRdAddr_r <= memRdAddr_nxt;
			reqReady_r  <= reqReady_nxt;
			opValid_r   <= opValid_nxt;
			opError_r   <= opError_nxt;
			opAddr_r    <= opAddr_nxt;
			opHiAddr_r  <= opHiAddr_nxt;
		end
	end

	// banked pointer file, eight banks of four 24-bit pointers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 32; i++) begin
				ptrFile_r[i] <= `OAG_PTR_RST;
			end
		end else if (ptrWe) begin
			ptrFile_r[ptrWIdx] <= ptrWData;
		end
	end

	// outputs straight from flip-flops
	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign reqReady  = reqReady_r;
	assign memRdReq  = memRdReq_r;
	assign memRdAddr = memRdAddr_r;
	assign opValid   = opValid_r;
	assign opAddr    = opAddr_r;
	assign opHiAddr  = opHiAddr_r;
	assign opError   = opError_r;

	// checks on generated addresses
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_direct;
		accept && reqMode == OAG_DIRECT24 && !reqErr |=> opValid_r && opAddr_r == $past(reqImm);
	endproperty
	a_direct: assert property (p_direct) else $error("direct address not passed through");

	property p_short_loc;
		accept && reqMode == OAG_SHORT |=> opAddr_r[19:16] == $past(locNib) && opAddr_r[7:0] == $past(imm8);
	endproperty
	a_short_loc: assert property (p_short_loc) else $error("short address location nibble wrong");

	property p_mid_one;
		accept && reqMode == OAG_SHORT && !reqClassTwo |=> opAddr_r[9:8] == `OAG_MID_ONE;
	endproperty
	a_mid_one: assert property (p_mid_one) else $error("class one middle bits wrong");

	property p_hi_byte;
		accept && reqMode == OAG_SHORT && reqClassTwo && imm8 == `OAG_SHORT_TOP |=> opHiAddr_r[15:0] == `OAG_HI_WRAP;
	endproperty
	a_hi_byte: assert property (p_hi_byte) else $error("high byte address not next");

	property p_range;
		accept && reqMode == OAG_SHORT && reqSize == `OAG_SIZE_THREE && sfrSide |=> opValid_r && opError_r;
	endproperty
	a_range: assert property (p_range) else $error("three byte short access in sfr part accepted");

	property p_sfr;
		accept && reqMode == OAG_SFR |=> opAddr_r[15:8] == `OAG_SFR_PAGE && opError_r == ($past(imm8) < `OAG_SFR_SPLIT);
	endproperty
	a_sfr: assert property (p_sfr) else $error("sfr window or low-part check wrong");

	property p_ind_top;
		state_r == OAG_FETCH && memRdReq_r && memRdAck && cnt_r == need_r && need_r == `OAG_LAST16
			|=> opValid_r && opAddr_r[23:16] == `OAG_IND_TOP;
	endproperty
	a_ind_top: assert property (p_ind_top) else $error("indirect 16 top byte not zero");

	property p_ind_start;
		accept && reqMode == OAG_IND24 && !reqErr |=> memRdReq_r && memRdAddr_r == $past(shortAddr) && !reqReady_r;
	endproperty
	a_ind_start: assert property (p_ind_start) else $error("indirect fetch did not start at pointer");

	property p_push;
		accept && reqMode == OAG_PUSH && !reqErr |=> sp_r == $past(spStepDn) && opAddr_r == sp_r;
	endproperty
	a_push: assert property (p_push) else $error("push did not lower stack pointer");

	property p_step_up;
		accept && reqMode == OAG_REGIND && reqStep == OAG_STEP_INC && !reqErr
			|=> ptrFile_r[$past(ptrIdx)] == $past(ptrStepUp) && opAddr_r == $past(ptrVal);
	endproperty
	a_step_up: assert property (p_step_up) else $error("post increment wrong");

	property p_restrict;
		accept && reqRestricted && reqMode == OAG_REGIND && reqPtrSel == `OAG_SEL_FOUR |=> opError_r;
	endproperty
	a_restrict: assert property (p_restrict) else $error("restricted operand accepted bad pointer");

endmodule : oag_operand_address_generator

// ---- oag_pkg.sv ----
// oag_pkg.sv: types of the operand address generator
// assumes oag_map.svh holds every number
package oag_pkg;
	typedef enum logic [3:0] {
		OAG_DIRECT24, OAG_SHORT, OAG_SFR, OAG_IND16, OAG_IND24,
		OAG_PUSH, OAG_POP, OAG_UPUSH, OAG_UPOP, OAG_REGIND
	} oag_mode_type;
	typedef enum logic [1:0] {OAG_STEP_NONE, OAG_STEP_INC, OAG_STEP_DEC} oag_step_type;
	typedef enum logic [1:0] {OAG_IDLE, OAG_FETCH} oag_state_type;
endpackage : oag_pkg

// ---- test_operand_address_generator.sv ----
// test_operand_address_generator.sv: self-checking bench of the operand address generator
// assumes oag_pkg, the design and oag_mem_model are compiled first
`timescale 1ns/1ps
module test_operand_address_generator;
	import oag_pkg::*;
	logic         clk_sys = 1'h0;
	logic         rst_n = 1'h0;
	logic [7:0]   paddr = 8'h00;
	logic         psel = 1'h0;
	logic         penable = 1'h0;
	logic         pwrite = 1'h0;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         reqValid = 1'h0;
	oag_mode_type reqMode = OAG_DIRECT24;
	logic [23:0]  reqImm = 24'h0;
	logic         reqClassTwo = 1'h0;
	logic [1:0]   reqSize = 2'h1;
	logic [1:0]   reqPtrSel = 2'h0;
	oag_step_type reqStep = OAG_STEP_NONE;
	logic         reqRestricted = 1'h0;
	logic         reqReady;
	logic         ptrWrEn = 1'h0;
	logic [1:0]   ptrWrSel = 2'h0;
	logic [23:0]  ptrWrData = 24'h0;
	logic         memRdReq;
	logic [23:0]  memRdAddr;
	logic         memRdAck;
	logic [7:0]   memRdData;
	logic         opValid;
	logic [23:0]  opAddr;
	logic [23:0]  opHiAddr;
	logic         opError;
	logic [1:0]   stall = 2'h0;
	logic         cls2 = 1'h0;
	logic [1:0]   siz = 2'h1;
	logic [1:0]   sel = 2'h0;
	oag_step_type stp = OAG_STEP_NONE;
	logic         rsr = 1'h0;
	logic [31:0]  rd;
	logic         err;
	int           n_fail = 0;
	int           cmp_count = 0;
	int           cycles = 0;

	oag_operand_address_generator u_dut (
		.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.reqValid, .reqMode, .reqImm, .reqClassTwo, .reqSize, .reqPtrSel, .reqStep, .reqRestricted,
		.reqReady, .ptrWrEn, .ptrWrSel, .ptrWrData, .memRdReq, .memRdAddr, .memRdAck, .memRdData,
		.opValid, .opAddr, .opHiAddr, .opError
	);
	oag_mem_model u_mem (.clk_sys, .stall, .memRdReq, .memRdAddr, .memRdAck, .memRdData);

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	// cut a hang short
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check_val(input string what, input logic [31:0] expv, input logic [31:0] got);
		cmp_count++;
		if (got !== expv) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, expv, got);
		end
	endtask : check_val

	function automatic logic [23:0] sh(input logic loc, input logic c2, input logic [7:0] imm);
		return {4'h0, {4{loc}}, 6'h3f, c2 ? (imm < 8'h20 ? 2'h3 : 2'h1) : 2'h2, imm};
	endfunction : sh

	function automatic logic [7:0] bt(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : bt

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel   <= 1'h1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 40);
		if (pready !== 1'h1) begin
			n_fail++;
			$display("[FAIL] apb pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] expv);
		apb(1'h0, a, 32'h0);
		check_val(what, expv, rd);
	endtask : rchk

	task automatic ptr_wr(input logic [1:0] s, input logic [23:0] d);
		@(posedge clk_sys);
		ptrWrEn   <= 1'h1;
		ptrWrSel  <= s;
		ptrWrData <= d;
		@(posedge clk_sys);
		ptrWrEn <= 1'h0;
	endtask : ptr_wr

	// one decoder request; the size, class, pointer and step come from the bench variables
	task automatic op(input oag_mode_type m, input logic [23:0] imm, input logic xe, input logic [23:0] xa);
		int n;
		n = 0;
		@(posedge clk_sys);
		while (reqReady !== 1'h1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		reqValid      <= 1'h1;
		reqMode       <= m;
		reqImm        <= imm;
		reqClassTwo   <= cls2;
		reqSize       <= siz;
		reqPtrSel     <= sel;
		reqStep       <= stp;
		reqRestricted <= rsr;
		@(posedge clk_sys);
		reqValid <= 1'h0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (opValid !== 1'h1 && n < 40);
		check_val("opValid", 32'h1, {31'h0, opValid});
		check_val("opError", {31'h0, xe}, {31'h0, opError});
		if (!xe) begin
			check_val("opAddr", {8'h0, xa}, {8'h0, opAddr});
			check_val("opHiAddr", {8'h0, xa + 24'h1}, {8'h0, opHiAddr});
		end
	endtask : op

	task automatic t_regs();
		rchk("ctrl", 8'h00, 32'h0);
		rchk("sp", 8'h04, 32'h0);
		rchk("stat", 8'h08, 32'h0);
		rchk("last", 8'h0c, 32'h0);
		apb(1'h0, 8'h10, 32'h0);
		check_val("unmapped err", 32'h1, {31'h0, err});
		apb(1'h1, 8'h00, 32'hffffffff);
		rchk("ctrl", 8'h00, 32'hf);
		siz = 2'h1;
		op(OAG_DIRECT24, 24'h54fe00, 1'h0, 24'h54fe00);
		op(OAG_DIRECT24, 24'hffffff, 1'h0, 24'hffffff);
		rchk("last", 8'h0c, 32'hffffff);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_short(input logic loc);
		logic [23:0] a;
		logic        xe;
		logic [7:0]  imms [6];
		imms = '{8'h00, 8'h1f, 8'h20, 8'hfd, 8'hfe, 8'hff};
		apb(1'h1, 8'h00, {31'h0, loc});
		for (int c = 0; c < 2; c++) begin
			for (int s = 1; s < 4; s++) begin
				foreach (imms[i]) begin
					a = sh(loc, c[0], imms[i]);
					xe = (s == 2 && (a[15:0] == 16'hfeff || a[15:0] == 16'hff1f)) || (s == 3 && a[15:0] > 16'hfefd);
					cls2 = c[0];
					siz = s[1:0];
					op(OAG_SHORT, {16'h0, imms[i]}, xe, a);
				end
			end
		end
		$display("t_short done");
	endtask : t_short

	task automatic t_sfr();
		logic [7:0] imms [4];
		imms = '{8'h10, 8'h1f, 8'h20, 8'hff};
		siz = 2'h1;
		for (int l = 0; l < 2; l++) begin
			apb(1'h1, 8'h00, {31'h0, l[0]});
			foreach (imms[i]) begin
				op(OAG_SFR, {16'h0, imms[i]}, imms[i] < 8'h20, {4'h0, {4{l[0]}}, 8'hff, imms[i]});
			end
		end
		$display("t_sfr done");
	endtask : t_sfr

	task automatic t_ind();
		logic [23:0] p;
		siz = 2'h1;
		for (int l = 0; l < 2; l++) begin
			apb(1'h1, 8'h00, {31'h0, l[0]});
			stall <= l[0] ? 2'h2 : 2'h0;
			cls2 = 1'h0;
			p = sh(l[0], 1'h0, 8'ha0);
			op(OAG_IND16, 24'ha0, 1'h0, {8'h00, bt(p + 24'h1), bt(p)});
			op(OAG_IND16, 24'hff, 1'h1, 24'h0);
			op(OAG_IND24, 24'hfe, 1'h1, 24'h0);
			cls2 = 1'h1;
			p = sh(l[0], 1'h1, 8'h30);
			op(OAG_IND24, 24'h30, 1'h0, {bt(p + 24'h2), bt(p + 24'h1), bt(p)});
			op(OAG_IND24, 24'h10, 1'h1, 24'h0);
		end
		$display("t_ind done");
	endtask : t_ind

	task automatic t_stack();
		apb(1'h1, 8'h04, 32'h001000);
		siz = 2'h2;
		op(OAG_PUSH, 24'h0, 1'h0, 24'h000ffe);
		rchk("sp", 8'h04, 32'h000ffe);
		op(OAG_POP, 24'h0, 1'h0, 24'h000ffe);
		rchk("sp", 8'h04, 32'h001000);
		sel = 2'h1;
		ptr_wr(2'h1, 24'h002000);
		op(OAG_UPUSH, 24'h0, 1'h0, 24'h001ffe);
		rchk("sp", 8'h04, 32'h001000);
		op(OAG_UPOP, 24'h0, 1'h0, 24'h001ffe);
		op(OAG_REGIND, 24'h0, 1'h0, 24'h002000);
		siz = 2'h0;
		op(OAG_PUSH, 24'h0, 1'h1, 24'h0);
		siz = 2'h3;
		op(OAG_POP, 24'h0, 1'h0, 24'h001000);
		rchk("sp", 8'h04, 32'h001003);
		$display("t_stack done");
	endtask : t_stack

	task automatic t_regind();
		apb(1'h1, 8'h00, 32'h6);
		ptr_wr(2'h2, 24'h123456);
		sel = 2'h2;
		stp = OAG_STEP_NONE;
		siz = 2'h1;
		op(OAG_REGIND, 24'h0, 1'h0, 24'h123456);
		apb(1'h1, 8'h00, 32'h0);
		op(OAG_REGIND, 24'h0, 1'h0, 24'h000000);
		apb(1'h1, 8'h00, 32'h6);
		stp = OAG_STEP_INC;
		siz = 2'h3;
		op(OAG_REGIND, 24'h0, 1'h0, 24'h123456);
		op(OAG_REGIND, 24'h0, 1'h0, 24'h123459);
		stp = OAG_STEP_DEC;
		siz = 2'h1;
		op(OAG_REGIND, 24'h0, 1'h0, 24'h12345c);
		op(OAG_REGIND, 24'h0, 1'h0, 24'h12345b);
		sel = 2'h3;
		ptr_wr(2'h3, 24'hffffff);
		stp = OAG_STEP_INC;
		siz = 2'h2;
		op(OAG_REGIND, 24'h0, 1'h0, 24'hffffff);
		op(OAG_REGIND, 24'h0, 1'h0, 24'h000001);
		stp = OAG_STEP_DEC;
		op(OAG_REGIND, 24'h0, 1'h0, 24'h000003);
		op(OAG_REGIND, 24'h0, 1'h0, 24'h000001);
		rsr = 1'h1;
		stp = OAG_STEP_INC;
		op(OAG_REGIND, 24'h0, 1'h1, 24'h0);
		stp = OAG_STEP_NONE;
		op(OAG_REGIND, 24'h0, 1'h0, 24'hffffff);
		sel = 2'h0;
		op(OAG_REGIND, 24'h0, 1'h1, 24'h0);
		sel = 2'h2;
		stp = OAG_STEP_DEC;
		op(OAG_REGIND, 24'h0, 1'h0, 24'h12345a);
		rchk("last", 8'h0c, 32'h12345a);
		rsr = 1'h0;
		sel = 2'h1;
		op(OAG_REGIND, 24'h0, 1'h1, 24'h0);
		rchk("last", 8'h0c, 32'h0);
		$display("t_regind done");
	endtask : t_regind

	// reset, then the scenarios in turn
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'h1;
		t_regs();
		t_short(1'h0);
		t_short(1'h1);
		t_sfr();
		t_ind();
		t_stack();
		t_regind();
		tally_and_finish();
	end
endmodule : test_operand_address_generator
